// File: inc/tvf_pkg.sv
// shared constants and types for the temperature / input-voltage fault limit block
`default_nettype none
package tvf_pkg;

  // ----------------------------------------------------------------------
  // management command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CMD_UT_FAULT_THR  = 8'h53;
  localparam logic [7:0]  CMD_UT_ACTION     = 8'h54;
  localparam logic [7:0]  CMD_VIN_OV_THR    = 8'h55;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] UT_FAULT_THR_RST  = 16'hE530;
  localparam logic [7:0]  UT_ACTION_RST     = 8'h80;
  localparam logic [15:0] VIN_OV_THR_RST    = 16'hDA00;
  localparam logic [15:0] RDATA_NONE        = 16'h0000;

  // ----------------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------------
  localparam int          EXP_MSB           = 15;
  localparam int          EXP_LSB           = 11;
  localparam int          MANT_MSB          = 10;
  localparam int          BEHAV_MSB         = 7;
  localparam int          BEHAV_LSB         = 6;
  localparam int          RETRY_MSB         = 5;
  localparam int          RETRY_LSB         = 3;
  localparam int          DELAY_MSB         = 2;
  localparam int          DELAY_LSB         = 0;
  localparam logic [1:0]  BEHAV_RETRY       = 2'h2;
  localparam logic [2:0]  RETRY_NONE        = 3'h0;

  // ----------------------------------------------------------------------
  // fixed-point view of decoded values and accepted ranges
  // ----------------------------------------------------------------------
  localparam int          Q_FRAC            = 8;
  localparam int          Q_W               = 40;
  localparam int          UT_MIN_C          = -55;
  localparam int          UT_MAX_C          = 25;
  localparam int          VIN_MIN_V         = 0;
  localparam int          VIN_MAX_V         = 18;
  localparam logic signed [Q_W-1:0] UT_MIN_Q  = Q_W'(UT_MIN_C * (1 << Q_FRAC));
  localparam logic signed [Q_W-1:0] UT_MAX_Q  = Q_W'(UT_MAX_C * (1 << Q_FRAC));
  localparam logic signed [Q_W-1:0] VIN_MIN_Q = Q_W'(VIN_MIN_V * (1 << Q_FRAC));
  localparam logic signed [Q_W-1:0] VIN_MAX_Q = Q_W'(VIN_MAX_V * (1 << Q_FRAC));
  localparam int          UT_RST_C          = -45;
  localparam logic signed [Q_W-1:0] UT_RST_Q  = Q_W'(UT_RST_C * (1 << Q_FRAC));

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          TICK_PERIOD_NS    = 1000000;
  localparam int          TICK_CYCLES       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          RETRY_UNIT_MS     = 35;
  localparam int          DLY_W             = 9;

  typedef enum logic [1:0] {
    TVF_ST_OFF,
    TVF_ST_RUN,
    TVF_ST_WAIT,
    TVF_ST_LATCHED
  } tvf_state_t;

endpackage : tvf_pkg
`default_nettype wire

// File: logic/tvf_l11_decode.sv
// exponent/mantissa word to signed fixed-point converter
`timescale 1ns/100ps
`default_nettype none
module tvf_l11_decode #(
  parameter int FRAC  = tvf_pkg::Q_FRAC,
  parameter int OUT_W = tvf_pkg::Q_W
) (
  input  wire logic [15:0]             word_i,
  output logic signed [OUT_W-1:0]      value_o
);

  logic signed [4:0]        exp_s;
  logic signed [10:0]       mant_s;
  logic signed [OUT_W-1:0]  mant_x;
  int                       sh;

  // value = mantissa * 2^exponent, scaled by 2^FRAC; small negative shifts truncate toward minus infinity
  always_comb begin
    exp_s  = signed'(word_i[tvf_pkg::EXP_MSB:tvf_pkg::EXP_LSB]);
    mant_s = signed'(word_i[tvf_pkg::MANT_MSB:0]);
    mant_x = OUT_W'(mant_s);
    sh     = int'(exp_s) + FRAC;
    if (sh >= 0) begin
      value_o = mant_x <<< sh;
    end else begin
      value_o = mant_x >>> (-sh);
    end
  end

endmodule : tvf_l11_decode
`default_nettype wire

// File: logic/tvf_fault_ctrl.sv
// under-temperature and input-overvoltage fault limits, response and retry control
`timescale 1ns/100ps
`default_nettype none
module tvf_fault_ctrl #(
  parameter int TICK_CYCLES = tvf_pkg::TICK_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic        cmd_wr_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        clear_faults_i,
  input  wire logic [15:0] ut_warn_thr_i,
  input  wire logic [15:0] vin_ov_warn_thr_i,
  input  wire logic [7:0]  vin_ov_action_i,
  input  wire logic [15:0] temp_read_i,
  input  wire logic [15:0] vin_read_i,
  input  wire logic        enable_pin_i,
  input  wire logic        operation_on_i,
  input  wire logic        bias_ok_i,
  input  wire logic        other_fault_i,
  output logic      [15:0] cmd_rdata_o,
  output logic             wr_reject_o,
  output logic             output_enable_o,
  output logic             alert_n_o,
  output logic             ut_fault_status_o,
  output logic             vin_ov_fault_status_o
);

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam int DW = tvf_pkg::DLY_W;

  // ----------------------------------------------------------------------
  // state and decoded values
  // ----------------------------------------------------------------------
  logic [15:0]               ut_thr_q, vin_thr_q;
  logic [7:0]                ut_act_q;
  logic                      en_meta_q, en_sync_q;
  logic [PRE_W-1:0]          pre_q;
  logic [DW-1:0]             dly_q, dly_d, dly_load;
  logic                      cause_ut_q, cause_ut_d;
  tvf_pkg::tvf_state_t       state_q, state_d;
  logic                      ut_stat_d, vin_stat_d;
  logic signed [tvf_pkg::Q_W-1:0] wr_val, ut_thr_v, ut_warn_v, vin_thr_v, vin_warn_v, temp_v, vin_v;
  logic                      cmd_on, tick, ut_det, vin_det, ut_clear, vin_clear, ut_ok, vin_ok;
  logic [7:0]                act;

  // one decoder per word; the write path is checked in decoded form
  tvf_l11_decode u_dec_wr   (.word_i(cmd_wdata_i),       .value_o(wr_val));
  tvf_l11_decode u_dec_utf  (.word_i(ut_thr_q),          .value_o(ut_thr_v));
  tvf_l11_decode u_dec_utw  (.word_i(ut_warn_thr_i),     .value_o(ut_warn_v));
  tvf_l11_decode u_dec_vinf (.word_i(vin_thr_q),         .value_o(vin_thr_v));
  tvf_l11_decode u_dec_vinw (.word_i(vin_ov_warn_thr_i), .value_o(vin_warn_v));
  tvf_l11_decode u_dec_temp (.word_i(temp_read_i),       .value_o(temp_v));
  tvf_l11_decode u_dec_vin  (.word_i(vin_read_i),        .value_o(vin_v));

  // ----------------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------------
  assign ut_det    = temp_v < ut_thr_v;
  assign vin_det   = vin_v > vin_thr_v;
  assign ut_clear  = temp_v > ut_warn_v;
  assign vin_clear = vin_v < vin_warn_v;
  assign ut_ok     = (wr_val >= tvf_pkg::UT_MIN_Q) && (wr_val <= tvf_pkg::UT_MAX_Q);
  assign vin_ok    = (wr_val >= tvf_pkg::VIN_MIN_Q) && (wr_val <= tvf_pkg::VIN_MAX_Q);
  // bias loss and another shutting fault act like an off command
  assign cmd_on    = en_sync_q && operation_on_i && bias_ok_i && !other_fault_i;
  assign act       = cause_ut_d ? ut_act_q : vin_ov_action_i;
  assign dly_load  = DW'((DW'(act[tvf_pkg::DELAY_MSB:tvf_pkg::DELAY_LSB]) + DW'(1)) * DW'(tvf_pkg::RETRY_UNIT_MS));
  assign tick      = (pre_q == '0);

  // ----------------------------------------------------------------------
  // enable pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
    end else begin
      en_meta_q <= enable_pin_i;
      en_sync_q <= en_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // settings: out-of-range writes are dropped and flagged for one cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ut_thr_q    <= tvf_pkg::UT_FAULT_THR_RST;
      ut_act_q    <= tvf_pkg::UT_ACTION_RST;
      vin_thr_q   <= tvf_pkg::VIN_OV_THR_RST;
      wr_reject_o <= 1'b0;
    end else begin
      wr_reject_o <= 1'b0;
      if (cmd_wr_i && cmd_code_i == tvf_pkg::CMD_UT_FAULT_THR) begin
        if (ut_ok) ut_thr_q <= cmd_wdata_i;
        else wr_reject_o <= 1'b1;
      end else if (cmd_wr_i && cmd_code_i == tvf_pkg::CMD_UT_ACTION) begin
        ut_act_q <= cmd_wdata_i[7:0];
      end else if (cmd_wr_i && cmd_code_i == tvf_pkg::CMD_VIN_OV_THR) begin
        if (vin_ok) vin_thr_q <= cmd_wdata_i;
        else wr_reject_o <= 1'b1;
      end
    end
  end

  // read data follows the command code one cycle later; unknown codes read zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_rdata_o <= tvf_pkg::RDATA_NONE;
    end else if (cmd_code_i == tvf_pkg::CMD_UT_FAULT_THR) begin
      cmd_rdata_o <= ut_thr_q;
    end else if (cmd_code_i == tvf_pkg::CMD_UT_ACTION) begin
      cmd_rdata_o <= {8'h00, ut_act_q};
    end else if (cmd_code_i == tvf_pkg::CMD_VIN_OV_THR) begin
      cmd_rdata_o <= vin_thr_q;
    end else begin
      cmd_rdata_o <= tvf_pkg::RDATA_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // output control state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    cause_ut_d = cause_ut_q;
    dly_d      = (tick && dly_q != '0) ? dly_q - DW'(1) : dly_q;
    case (state_q)
      tvf_pkg::TVF_ST_OFF: begin
        dly_d = '0;
        if (cmd_on) state_d = tvf_pkg::TVF_ST_RUN;
      end
      tvf_pkg::TVF_ST_RUN: begin
        if (!cmd_on) begin
          state_d = tvf_pkg::TVF_ST_OFF;
          dly_d   = '0;
        end else if ((ut_det && ut_act_q[tvf_pkg::BEHAV_MSB:tvf_pkg::BEHAV_LSB] == tvf_pkg::BEHAV_RETRY) ||
                     (vin_det && vin_ov_action_i[tvf_pkg::BEHAV_MSB:tvf_pkg::BEHAV_LSB] == tvf_pkg::BEHAV_RETRY)) begin
          // the under-temperature fault wins when both strike together
          cause_ut_d = ut_det && ut_act_q[tvf_pkg::BEHAV_MSB:tvf_pkg::BEHAV_LSB] == tvf_pkg::BEHAV_RETRY;
          if (act[tvf_pkg::RETRY_MSB:tvf_pkg::RETRY_LSB] == tvf_pkg::RETRY_NONE) begin
            state_d = tvf_pkg::TVF_ST_LATCHED;
          end else begin
            state_d = tvf_pkg::TVF_ST_WAIT;
            // a fresh fault waits the full delay; a refault keeps the attempt spacing
            if (dly_q == '0) dly_d = dly_load;
          end
        end
      end
      tvf_pkg::TVF_ST_WAIT: begin
        if (!cmd_on) begin
          state_d = tvf_pkg::TVF_ST_OFF;
          dly_d   = '0;
        end else if (dly_q == '0 && (cause_ut_q ? ut_clear : vin_clear)) begin
          state_d = tvf_pkg::TVF_ST_RUN;
          dly_d   = dly_load;
        end
      end
      tvf_pkg::TVF_ST_LATCHED: begin
        // only a full off/on cycle of the commands restarts a latched output
        if (!cmd_on) state_d = tvf_pkg::TVF_ST_OFF;
        dly_d = '0;
      end
      default: state_d = tvf_pkg::TVF_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q         <= tvf_pkg::TVF_ST_OFF;
      cause_ut_q      <= 1'b0;
      dly_q           <= '0;
      output_enable_o <= 1'b0;
    end else begin
      state_q         <= state_d;
      cause_ut_q      <= cause_ut_d;
      dly_q           <= dly_d;
      output_enable_o <= (state_d == tvf_pkg::TVF_ST_RUN);
    end
  end

  // millisecond prescaler; runs free so a delay may be short by under one tick
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= PRE_LAST;
    end else if (pre_q == '0) begin
      pre_q <= PRE_LAST;
    end else begin
      pre_q <= pre_q - PRE_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // sticky status and alert; a detection in the clearing cycle wins
  // ----------------------------------------------------------------------
  assign ut_stat_d  = ut_det || (ut_fault_status_o && !clear_faults_i);
  assign vin_stat_d = vin_det || (vin_ov_fault_status_o && !clear_faults_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ut_fault_status_o     <= 1'b0;
      vin_ov_fault_status_o <= 1'b0;
      alert_n_o             <= 1'b1;
    end else begin
      ut_fault_status_o     <= ut_stat_d;
      vin_ov_fault_status_o <= vin_stat_d;
      alert_n_o             <= !(ut_stat_d || vin_stat_d);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wait_to_run;
    state_q == tvf_pkg::TVF_ST_WAIT && state_d == tvf_pkg::TVF_ST_RUN;
  endsequence
  sequence s_run_to_wait;
    state_q == tvf_pkg::TVF_ST_RUN && state_d == tvf_pkg::TVF_ST_WAIT;
  endsequence

  AST_UT_DET_STATUS: assert property (ut_det |=> ut_fault_status_o && !alert_n_o)
    else $error("under-temperature not flagged");
  AST_UT_WR_REFUSE: assert property (cmd_wr_i && cmd_code_i == tvf_pkg::CMD_UT_FAULT_THR && !ut_ok
    |=> ut_thr_q == $past(ut_thr_q) && wr_reject_o) else $error("bad threshold write accepted");
  AST_UT_HYST: assert property (s_wait_to_run and cause_ut_q |-> ut_clear)
    else $error("retry before temperature recovered");
  AST_DECODE_RST: assert property (ut_thr_q == tvf_pkg::UT_FAULT_THR_RST |-> ut_thr_v == tvf_pkg::UT_RST_Q)
    else $error("threshold decode wrong");
  AST_BEHAV_ONLY_RETRY: assert property (state_q == tvf_pkg::TVF_ST_RUN ##1 state_q == tvf_pkg::TVF_ST_WAIT
    |-> (cause_ut_q ? ut_act_q[7:6] : vin_ov_action_i[7:6]) == tvf_pkg::BEHAV_RETRY) else $error("unused code acted");
  AST_STICKY: assert property (ut_fault_status_o && !clear_faults_i |=> ut_fault_status_o [*1] ##0 !alert_n_o)
    else $error("status dropped without clear");
  AST_LATCH_HOLD: assert property (state_q == tvf_pkg::TVF_ST_LATCHED && cmd_on |=> !output_enable_o)
    else $error("latched output restarted");
  AST_OFF_STOPS: assert property (state_q == tvf_pkg::TVF_ST_WAIT && !cmd_on |=> state_q == tvf_pkg::TVF_ST_OFF ##1
    !output_enable_o) else $error("retry not stopped by off");
  AST_SPACING: assert property (s_wait_to_run |=> dly_q == $past(dly_load) && output_enable_o)
    else $error("attempt delay not reloaded");
  AST_FIRST_DELAY: assert property (s_run_to_wait and dly_q == '0 |=> dly_q == $past(dly_load))
    else $error("first retry delay not loaded");
  AST_VIN_WR_REFUSE: assert property (cmd_wr_i && cmd_code_i == tvf_pkg::CMD_VIN_OV_THR && !vin_ok
    |=> vin_thr_q == $past(vin_thr_q)) else $error("bad vin threshold accepted");
  AST_VIN_HYST: assert property (s_wait_to_run and !cause_ut_q |-> vin_clear)
    else $error("retry before input recovered");

endmodule : tvf_fault_ctrl
`default_nettype wire

// File: test/tvf_host.sv
// host-side model: register writes and reads, clear-faults and warning limits
`timescale 1ns/100ps
`default_nettype none
module tvf_host (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] cmd_rdata_i,
  input  wire logic        wr_reject_i,
  output logic      [7:0]  cmd_code_o,
  output logic             cmd_wr_o,
  output logic      [15:0] cmd_wdata_o,
  output logic             clear_faults_o,
  output logic      [15:0] ut_warn_thr_o,
  output logic      [15:0] vin_ov_warn_thr_o,
  output logic      [7:0]  vin_ov_action_o
);
  // warning limits stay on the safe side of the fault limits, else restarts can fire while the fault level is still crossed
  assign ut_warn_thr_o     = 16'h07E2;
  assign vin_ov_warn_thr_o = 16'h000F;
  assign vin_ov_action_o   = 8'h89;    // disable and retry, delay field 1

  // idle bus at time zero
  initial begin
    cmd_code_o     = 8'h00;
    cmd_wr_o       = 1'b0;
    cmd_wdata_o    = 16'h0000;
    clear_faults_o = 1'b0;
  end

  // one-cycle strobe; the refusal flag is registered one edge behind it
  task automatic write_reg(input logic [7:0] code, input logic [15:0] data, output logic rej);
    @(posedge clk_sys_i);
    cmd_code_o  <= code;
    cmd_wr_o    <= 1'b1;
    cmd_wdata_o <= data;
    @(posedge clk_sys_i);
    cmd_wr_o <= 1'b0;
    #1;
    rej = wr_reject_i;
  endtask : write_reg

  // read data is registered one cycle behind the code
  task automatic read_reg(input logic [7:0] code, output logic [15:0] data);
    @(posedge clk_sys_i);
    cmd_code_o <= code;
    @(posedge clk_sys_i);
    #1;
    data = cmd_rdata_i;
  endtask : read_reg

  // clear-faults is a single-cycle command pulse
  task automatic clear_faults();
    @(posedge clk_sys_i);
    clear_faults_o <= 1'b1;
    @(posedge clk_sys_i);
    clear_faults_o <= 1'b0;
  endtask : clear_faults
endmodule : tvf_host
`default_nettype wire

// File: test/tvf_fault_ctrl_bench.sv
// self-checking bench for the fault limit and response block
`timescale 1ns/100ps
`default_nettype none
module tvf_fault_ctrl_bench;
  localparam int          TK      = 4;
  localparam int          DLY     = 2 * 35 * TK; // delay field 1: two 35-tick units
  localparam logic [15:0] WARM    = 16'h001E;    // +30 C
  localparam logic [15:0] EDGE_T  = 16'h07D3;    // -45 C, equal to the fault level
  localparam logic [15:0] COLD    = 16'h07D2;    // -46 C
  localparam logic [15:0] MID_T   = 16'h07D8;    // -40 C, between fault and warning
  localparam logic [15:0] VIN_OK  = 16'h000C;    // 12 V
  localparam logic [15:0] VIN_HI  = 16'h0011;    // 17 V
  localparam logic [15:0] VIN_MID = 16'h0010;    // 16 V, above the warning, equal to the fault level

  logic        clk_sys_i, rst_n_i, enable_pin, operation_on, bias_ok, other_fault;
  logic [15:0] temp_read, vin_read, cmd_wdata, ut_warn, vin_warn, cmd_rdata;
  logic [7:0]  cmd_code, vin_action;
  logic        cmd_wr, clear_faults, wr_reject, output_enable_o, alert_n, ut_stat, vin_stat;
  int          err_count   = 0;
  int          check_count = 0;

  // ----------------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  tvf_fault_ctrl #(.TICK_CYCLES(TK)) u_tvf_fault_ctrl (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_code_i(cmd_code), .cmd_wr_i(cmd_wr),
    .cmd_wdata_i(cmd_wdata), .clear_faults_i(clear_faults), .ut_warn_thr_i(ut_warn),
    .vin_ov_warn_thr_i(vin_warn), .vin_ov_action_i(vin_action), .temp_read_i(temp_read),
    .vin_read_i(vin_read), .enable_pin_i(enable_pin), .operation_on_i(operation_on),
    .bias_ok_i(bias_ok), .other_fault_i(other_fault), .cmd_rdata_o(cmd_rdata),
    .wr_reject_o(wr_reject), .output_enable_o(output_enable_o), .alert_n_o(alert_n),
    .ut_fault_status_o(ut_stat), .vin_ov_fault_status_o(vin_stat));

  tvf_host u_tvf_host (
    .clk_sys_i(clk_sys_i), .cmd_rdata_i(cmd_rdata), .wr_reject_i(wr_reject), .cmd_code_o(cmd_code),
    .cmd_wr_o(cmd_wr), .cmd_wdata_o(cmd_wdata), .clear_faults_o(clear_faults),
    .ut_warn_thr_o(ut_warn), .vin_ov_warn_thr_o(vin_warn), .vin_ov_action_o(vin_action));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] d;
    u_tvf_host.read_reg(c, d);
    chk(d, exp);
  endtask : rd

  task automatic wr(input logic [7:0] c, input logic [15:0] v, input logic rej_exp);
    logic r;
    u_tvf_host.write_reg(c, v, r);
    chk({15'h0000, r}, {15'h0000, rej_exp});
  endtask : wr

  // alert and both sticky bits in one compare
  task automatic stat(input logic ut, input logic vn, input logic an);
    chk({13'h0000, ut_stat, vin_stat, alert_n}, {13'h0000, ut, vn, an});
  endtask : stat

  task automatic drive(input logic [15:0] t, input logic [15:0] v, input logic o);
    @(posedge clk_sys_i);
    temp_read    <= t;
    vin_read     <= v;
    operation_on <= o;
  endtask : drive

  // bounded wait for the output level; n counts the cycles taken
  task automatic wait_oe(input logic v, input int lim, output int n);
    n = 0;
    // step off the launching edge so the output's new value is the one seen
    #1;
    while (output_enable_o !== v) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > lim) begin
        err_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, output_enable_o, v);
        give_verdict();
      end
    end
  endtask : wait_oe

  task automatic hold(input logic v, input int cyc);
    repeat (cyc) begin
      @(posedge clk_sys_i);
      #1;
      chk({15'h0000, output_enable_o}, {15'h0000, v});
    end
  endtask : hold

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int          n;
    logic [7:0]  codes [3] = '{8'h08, 8'h48, 8'hC8};
    rst_n_i = 1'b0;
    {enable_pin, operation_on, other_fault} = 3'b000;
    bias_ok   = 1'b1;
    temp_read = WARM;
    vin_read  = VIN_OK;
    repeat (10) @(posedge clk_sys_i);
    #1;
    stat(1'b0, 1'b0, 1'b1);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'h53, 16'hE530);
    rd(8'h54, 16'h0080);
    rd(8'h55, 16'hDA00);
    wr(8'h53, 16'h07C4, 1'b1);
    wr(8'h53, 16'hF833, 1'b1);
    wr(8'h53, 16'hFF91, 1'b1);
    rd(8'h53, 16'hE530);
    wr(8'h53, 16'hF832, 1'b0);
    rd(8'h53, 16'hF832);
    wr(8'h53, 16'h07C9, 1'b0);
    rd(8'h53, 16'h07C9);
    wr(8'h55, 16'h0013, 1'b1);
    wr(8'h55, 16'hF825, 1'b1);
    wr(8'h55, 16'h07FF, 1'b1);
    rd(8'h55, 16'hDA00);
    wr(8'h55, 16'h0809, 1'b0);
    rd(8'h55, 16'h0809);
    wr(8'h56, 16'h1234, 1'b0);
    rd(8'h56, 16'h0000);
    wr(8'h54, 16'h00A5, 1'b0);
    rd(8'h54, 16'h00A5);
    wr(8'h53, 16'hE530, 1'b0);
    wr(8'h55, 16'hDA00, 1'b0);
    stat(1'b0, 1'b0, 1'b1);
    $display("test registers done");
    // power on, then sit exactly on the fault level
    @(posedge clk_sys_i);
    enable_pin <= 1'b1;
    drive(EDGE_T, VIN_OK, 1'b1);
    wait_oe(1'b1, 20, n);
    hold(1'b1, 10);
    stat(1'b0, 1'b0, 1'b1);
    // unused behaviour codes flag the fault but leave the output on
    foreach (codes[i]) begin
      wr(8'h54, {8'h00, codes[i]}, 1'b0);
      drive(COLD, VIN_OK, 1'b1);
      hold(1'b1, 10);
      stat(1'b1, 1'b0, 1'b0);
      drive(WARM, VIN_OK, 1'b1);
      hold(1'b1, 10);
      stat(1'b1, 1'b0, 1'b0);
      u_tvf_host.clear_faults();
      @(posedge clk_sys_i);
      #1;
      stat(1'b0, 1'b0, 1'b1);
    end
    $display("test unused codes done");
    // no-retry setting latches off until a commanded restart
    wr(8'h54, 16'h0080, 1'b0);
    drive(COLD, VIN_OK, 1'b1);
    wait_oe(1'b0, 3, n);
    drive(WARM, VIN_OK, 1'b1);
    hold(1'b0, DLY + 40);
    drive(WARM, VIN_OK, 1'b0);
    drive(WARM, VIN_OK, 1'b1);
    wait_oe(1'b1, 20, n);
    u_tvf_host.clear_faults();
    $display("test latch done");
    // retry: first delay, attempt spacing, warning hysteresis
    wr(8'h54, 16'h0089, 1'b0);
    drive(COLD, VIN_OK, 1'b1);
    drive(WARM, VIN_OK, 1'b1);
    wait_oe(1'b1, 400, n);
    chk({15'h0000, n >= DLY - 6 && n <= DLY + 6}, 16'h0001);
    hold(1'b1, 10);
    drive(COLD, VIN_OK, 1'b1);
    drive(WARM, VIN_OK, 1'b1);
    wait_oe(1'b1, 400, n);
    chk({15'h0000, n + 12 >= DLY - 8 && n + 12 <= DLY + 8}, 16'h0001);
    drive(COLD, VIN_OK, 1'b1);
    drive(MID_T, VIN_OK, 1'b1);
    hold(1'b0, DLY + 40);
    drive(WARM, VIN_OK, 1'b1);
    wait_oe(1'b1, 20, n);
    drive(COLD, VIN_OK, 1'b1);
    drive(WARM, VIN_OK, 1'b0);
    hold(1'b0, DLY + 40);
    drive(WARM, VIN_OK, 1'b1);
    wait_oe(1'b1, DLY + 40, n);
    drive(COLD, VIN_OK, 1'b1);
    bias_ok <= 1'b0;
    drive(WARM, VIN_OK, 1'b1);
    hold(1'b0, DLY + 40);
    @(posedge clk_sys_i);
    bias_ok <= 1'b1;
    wait_oe(1'b1, DLY + 40, n);
    // another shutting fault also stops the retries until it goes away
    drive(COLD, VIN_OK, 1'b1);
    other_fault <= 1'b1;
    drive(WARM, VIN_OK, 1'b1);
    hold(1'b0, DLY + 40);
    @(posedge clk_sys_i);
    other_fault <= 1'b0;
    wait_oe(1'b1, DLY + 40, n);
    u_tvf_host.clear_faults();
    $display("test retry done");
    // input overvoltage waits for the warning level before restarting
    drive(WARM, VIN_HI, 1'b1);
    drive(WARM, VIN_MID, 1'b1);
    hold(1'b0, DLY + 40);
    stat(1'b0, 1'b1, 1'b0);
    drive(WARM, VIN_OK, 1'b1);
    wait_oe(1'b1, 20, n);
    $display("test input overvoltage done");
    give_verdict();
  end
endmodule : tvf_fault_ctrl_bench
`default_nettype wire
